//--- cfg_pkg.sv
/*
  Constants for the brightness and short detection configuration register.
  Assumes an APB master on the same clock as the register bank.
*/
package cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int CFG_W = 48;
  localparam logic [ADDR_W-1:0] CFG_LO_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] CFG_HI_ADDR = 8'h04;
  localparam logic [CFG_W-1:0] CFG_RESET = 48'h003b_7f7f_7f00;
  localparam logic [CFG_W-1:0] CFG_WMASK = 48'hffff_ffff_ff00;
  localparam int RED_LSB = 8;
  localparam int GREEN_LSB = 16;
  localparam int BLUE_LSB = 24;
  localparam int GLOBAL_LSB = 32;
  localparam int REMOVAL_LSB = 35;
  localparam int RED_VTH_LSB = 39;
  localparam int GREEN_VTH_LSB = 42;
  localparam int BLUE_VTH_LSB = 45;
  localparam int WORD_W = 32;
  localparam int HI_LSB = 32;
  localparam int RSVD_W = 8;
  localparam int COLOR_W = 8;
  localparam int LEVEL_W = 3;
  localparam int REMOVAL_W = 4;
  localparam int VTH_W = 3;
  localparam logic [RSVD_W-1:0] RSVD_ZERO = 8'h00;
endpackage : cfg_pkg

//--- cfg_word_reg.sv
/*
  One 48-bit configuration word with per-bit write mask.
  Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module cfg_word_reg (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] wr_en,
  input wire logic [31:0] wr_data,
  output logic [cfg_pkg::CFG_W-1:0] value
);
  import cfg_pkg::*;
  logic [CFG_W-1:0] next_value;
  logic [CFG_W-1:0] wr_word;

  always_comb begin
    wr_word = value;
    if (wr_en[0]) begin
      wr_word[WORD_W-1:0] = wr_data;
    end
    if (wr_en[1]) begin
      wr_word[CFG_W-1:HI_LSB] = wr_data[CFG_W-HI_LSB-1:0];
    end
    // Reserved low bits are masked so a write can never disturb them.
    next_value = wr_word & CFG_WMASK;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      value <= CFG_RESET;
    end else begin
      value <= next_value;
    end
  end
endmodule : cfg_word_reg

//--- brightness_and_short_detect_config.sv
/*
  APB slave holding the brightness and short detection configuration word.
  Assumes an APB master on mclk; the fields drive analog blocks directly.
*/
`timescale 1ns/1ps
module brightness_and_short_detect_config (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] red_color_brightness,
  output logic [7:0] green_color_brightness,
  output logic [7:0] blue_color_brightness,
  output logic [2:0] global_brightness_level,
  output logic [3:0] short_removal_level,
  output logic [2:0] red_short_detect_threshold,
  output logic [2:0] green_short_detect_threshold,
  output logic [2:0] blue_short_detect_threshold
);
  import cfg_pkg::*;
  logic [CFG_W-1:0] cfg;
  logic [1:0] wr_en;
  logic access;
  logic hit_lo;
  logic hit_hi;
  logic [31:0] next_prdata;
  logic next_pslverr;

  assign access = psel && penable;
  // One compare for both words keeps read and write decode alike.
  function automatic logic addr_match(input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] b);
    return a == b;
  endfunction : addr_match

  assign hit_lo = addr_match(paddr, CFG_LO_ADDR);
  assign hit_hi = addr_match(paddr, CFG_HI_ADDR);
  // Zero wait states keep the slave simple; reads come from a register.
  assign pready = 1'b1;
  assign wr_en = {access && pwrite && hit_hi, access && pwrite && hit_lo};

  cfg_word_reg u_word (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_data(pwdata),
    .value(cfg)
  );

  // Read data is registered in the setup cycle so it is stable in access.
  always_comb begin
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (hit_lo) begin
        next_prdata = cfg[WORD_W-1:0];
      end else if (hit_hi) begin
        next_prdata = {{(2*WORD_W-CFG_W){1'b0}}, cfg[CFG_W-1:HI_LSB]};
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (access) begin
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign red_color_brightness = cfg[RED_LSB +: COLOR_W];
  assign green_color_brightness = cfg[GREEN_LSB +: COLOR_W];
  assign blue_color_brightness = cfg[BLUE_LSB +: COLOR_W];
  assign global_brightness_level = cfg[GLOBAL_LSB +: LEVEL_W];
  // Code 15 is passed raw; the analog side maps it to level 15 as well.
  assign short_removal_level = cfg[REMOVAL_LSB +: REMOVAL_W];
  assign red_short_detect_threshold = cfg[RED_VTH_LSB +: VTH_W];
  assign green_short_detect_threshold = cfg[GREEN_VTH_LSB +: VTH_W];
  assign blue_short_detect_threshold = cfg[BLUE_VTH_LSB +: VTH_W];

  // All checks run on mclk and sleep while the reset is asserted.
  a_reserved_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cfg[RSVD_W-1:0] == RSVD_ZERO)
    else $error("reserved bits not zero");

  // A write lands at the access edge and shows on the fields one cycle on.
  a_red_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && pwrite && hit_lo
    |=> red_color_brightness == $past(pwdata[RED_LSB +: COLOR_W]))
    else $error("red brightness not written");

  a_green_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && pwrite && hit_lo
    |=> green_color_brightness == $past(pwdata[GREEN_LSB +: COLOR_W]))
    else $error("green brightness not written");

  a_blue_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && pwrite && hit_lo
    |=> blue_color_brightness == $past(pwdata[BLUE_LSB +: COLOR_W]))
    else $error("blue brightness not written");

  a_global_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && pwrite && hit_hi
    |=> global_brightness_level ==
    $past(pwdata[GLOBAL_LSB-HI_LSB +: LEVEL_W]))
    else $error("global level not written");

  a_removal_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && pwrite && hit_hi
    |=> short_removal_level ==
    $past(pwdata[REMOVAL_LSB-HI_LSB +: REMOVAL_W]))
    else $error("removal level not written");

  a_red_vth_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && pwrite && hit_hi
    |=> red_short_detect_threshold ==
    $past(pwdata[RED_VTH_LSB-HI_LSB +: VTH_W]))
    else $error("red threshold not written");

  a_red_vth_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !(access && pwrite && hit_hi)
    |=> $stable(red_short_detect_threshold))
    else $error("red threshold changed without write");

  a_green_vth_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && pwrite && hit_hi
    |=> green_short_detect_threshold ==
    $past(pwdata[GREEN_VTH_LSB-HI_LSB +: VTH_W]))
    else $error("green threshold not written");

  a_blue_vth_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && pwrite && hit_hi
    |=> blue_short_detect_threshold ==
    $past(pwdata[BLUE_VTH_LSB-HI_LSB +: VTH_W]))
    else $error("blue threshold not written");

  // The halves are written one at a time, so each must spare the other.
  a_hi_keeps_lo: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && pwrite && hit_hi
    |=> $stable(cfg[WORD_W-1:RSVD_W]))
    else $error("high write disturbed low word");

  a_lo_keeps_hi: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && pwrite && hit_lo
    |=> $stable(cfg[CFG_W-1:HI_LSB]))
    else $error("low write disturbed high word");

  a_idle_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !(access && pwrite && (hit_lo || hit_hi))
    |=> $stable(cfg))
    else $error("configuration changed without write");

  a_unmapped_ignored: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && pwrite && !hit_lo && !hit_hi
    |=> $stable(cfg))
    else $error("unmapped write changed configuration");

  // Read data are loaded at the setup edge, so access shows that value.
  a_read_low: assert property (
    @(posedge mclk) disable iff (!rst_n)
    psel && !penable && hit_lo ##1 access
    |-> prdata == cfg[WORD_W-1:0])
    else $error("low word read mismatch");

  a_read_high: assert property (
    @(posedge mclk) disable iff (!rst_n)
    psel && !penable && hit_hi ##1 access
    |-> prdata == {{(2*WORD_W-CFG_W){1'b0}}, cfg[CFG_W-1:HI_LSB]})
    else $error("high word read mismatch");

  a_read_reserved: assert property (
    @(posedge mclk) disable iff (!rst_n)
    psel && !penable && hit_lo ##1 access
    |-> prdata[RSVD_W-1:0] == RSVD_ZERO)
    else $error("reserved bits read nonzero");

  a_read_unmapped: assert property (
    @(posedge mclk) disable iff (!rst_n)
    psel && !penable && !hit_lo && !hit_hi ##1 access
    |-> prdata == {WORD_W{1'b0}})
    else $error("unmapped read not zero");

  // The error flag is meant for software that probes past the map.
  a_error_unmapped: assert property (
    @(posedge mclk) disable iff (!rst_n)
    psel && !penable && !hit_lo && !hit_hi ##1 access
    |-> pslverr)
    else $error("unmapped access without error");

  a_error_mapped: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && (hit_lo || hit_hi)
    |-> !pslverr)
    else $error("mapped access flagged as error");

  a_error_idle: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !psel
    |=> !pslverr)
    else $error("error flag raised while idle");

  a_rdata_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access
    |=> $stable(prdata))
    else $error("read data changed after access");
endmodule : brightness_and_short_detect_config

//--- apb_host.sv
/* APB host model that drives the register bank for the bench.
   Assumes mclk comes from the bench; any number of wait states. */
`timescale 1ns/1ps
module apb_host (
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
  end
  // Idle paddr and pwdata are inverted so that no stale value passes for a held one.
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // The answer is taken only at the edge that sees pready high.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : apb_host

//--- brightness_and_short_detect_config_tb.sv
/* Self-checking bench for the configuration register bank.
   Assumes the host model in apb_host and the constants of cfg_pkg. */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module brightness_and_short_detect_config_tb;
  import cfg_pkg::*;
  logic mclk = 0, rst_n = 0, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, red, green, blue;
  logic [31:0] pwdata, prdata, q, lo;
  logic [2:0] glob, rvth, gvth, bvth;
  logic [3:0] rem;
  logic [15:0] h;
  logic [47:0] v;
  int n_errors = 0, checks = 0;
  localparam logic RD = 1'b0;
  localparam logic WR = 1'b1;
  localparam logic OK = 1'b0;
  localparam logic ERR = 1'b1;
  always #20 mclk = ~mclk;
  apb_host host (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  brightness_and_short_detect_config dut (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .red_color_brightness(red), .green_color_brightness(green),
    .blue_color_brightness(blue), .global_brightness_level(glob),
    .short_removal_level(rem), .red_short_detect_threshold(rvth),
    .green_short_detect_threshold(gvth),
    .blue_short_detect_threshold(bvth));
  task automatic acc(input logic w, input logic [7:0] a,
      input logic [31:0] d, want, input logic err);
    logic e;
    host.xfer(w, a, d, q, e);
    `CHK(e, err)
    if (!w) `CHK(q, want)
  endtask : acc
  task automatic outs(input logic [47:0] x);
    @(negedge mclk);
    `CHK({bvth, gvth, rvth, rem, glob, blue, green, red, 8'h00}, x)
    `CHK(pready, 1'b1)
  endtask : outs
  task automatic stop_test;
    $display("Errors %0d, comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    outs(CFG_RESET);
    acc(RD, CFG_LO_ADDR, 32'h0, 32'h7f7f_7f00, OK);
    acc(RD, CFG_HI_ADDR, 32'h0, 32'h0000_003b, OK);
    acc(WR, CFG_LO_ADDR, 32'hffff_ffff, 32'h0, OK);
    acc(RD, CFG_LO_ADDR, 32'h0, 32'hffff_ff00, OK);
    // Every code of each 3-bit field, and the odd removal codes up to 4'hf.
    for (int i = 0; i < 8; i++) begin
      h = {3'(i), ~3'(i), 3'(i), 4'(2 * i + 1), 3'(i)};
      lo = {8'(i * 36), 8'(255 - i * 36), 8'(i * 17), 8'h5a};
      v = {h, lo[31:8], 8'h00};
      acc(WR, CFG_HI_ADDR, {16'hffff, h}, 32'h0, OK);
      acc(WR, CFG_LO_ADDR, lo, 32'h0, OK);
      outs(v);
      acc(RD, CFG_HI_ADDR, 32'h0, {16'h0, h}, OK);
      acc(RD, CFG_LO_ADDR, 32'h0, {lo[31:8], 8'h00}, OK);
    end
    acc(WR, 8'h08, 32'h0, 32'h0, ERR);
    acc(RD, 8'h08, 32'h0, 32'h0, ERR);
    outs(v);
    // A reset in mid-run must bring every field back at once.
    @(posedge mclk);
    rst_n <= 1'b0;
    outs(CFG_RESET);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    outs(CFG_RESET);
    acc(RD, CFG_HI_ADDR, 32'h0, 32'h0000_003b, OK);
    acc(RD, CFG_LO_ADDR, 32'h0, 32'h7f7f_7f00, OK);
    stop_test();
  end
endmodule : brightness_and_short_detect_config_tb
